//--- hdl/ams_pkg.sv
// Shared constants, types and decode helpers of the alert source mask bank.
package ams_pkg;

  // ****************************************************************
  // Command and selector codes
  // ****************************************************************
  localparam logic [7:0] CMD_ALERT_SOURCE_MASK = 8'h1b;
  localparam logic [7:0] SEL_OUTPUT_VOLTAGE = 8'h7a;
  localparam logic [7:0] SEL_OUTPUT_CURRENT = 8'h7b;
  localparam logic [7:0] SEL_INPUT = 8'h7c;
  localparam logic [7:0] SEL_TEMPERATURE = 8'h7d;
  localparam logic [7:0] PHASE_ALL = 8'hff;
  localparam logic [7:0] READ_BLOCK_LEN = 8'h01;

  // ****************************************************************
  // Group indices inside the mask array
  // ****************************************************************
  localparam logic [1:0] GRP_OUTPUT_VOLTAGE = 2'h0;
  localparam logic [1:0] GRP_OUTPUT_CURRENT = 2'h1;
  localparam logic [1:0] GRP_INPUT = 2'h2;
  localparam logic [1:0] GRP_TEMPERATURE = 2'h3;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int OUTPUT_OVERVOLTAGE_FAULT_MASK_BIT = 7;
  localparam int OUTPUT_OVERVOLTAGE_WARNING_MASK_BIT = 6;
  localparam int OUTPUT_UNDERVOLTAGE_WARNING_MASK_BIT = 5;
  localparam int OUTPUT_UNDERVOLTAGE_FAULT_MASK_BIT = 4;
  localparam int OUTPUT_LIMIT_RANGE_MASK_BIT = 3;
  localparam int TURN_ON_TIMEOUT_MASK_BIT = 2;
  localparam int OVERCURRENT_FAULT_MASK_BIT = 7;
  localparam int OVERCURRENT_WARNING_MASK_BIT = 5;
  localparam int UNDERCURRENT_FAULT_MASK_BIT = 4;
  localparam int INPUT_OVERVOLTAGE_FAULT_MASK_BIT = 7;
  localparam int INPUT_OVERVOLTAGE_WARNING_MASK_BIT = 6;
  localparam int INPUT_UNDERVOLTAGE_WARNING_MASK_BIT = 5;
  localparam int INSUFFICIENT_INPUT_MASK_BIT = 3;
  localparam int OVERTEMPERATURE_FAULT_MASK_BIT = 7;
  localparam int OVERTEMPERATURE_WARNING_MASK_BIT = 6;

  // ****************************************************************
  // Implemented bits and reset values
  // ****************************************************************
  localparam logic [7:0] OUTPUT_VOLTAGE_IMPL = (8'h01 << OUTPUT_OVERVOLTAGE_FAULT_MASK_BIT)
    | (8'h01 << OUTPUT_OVERVOLTAGE_WARNING_MASK_BIT)
    | (8'h01 << OUTPUT_UNDERVOLTAGE_WARNING_MASK_BIT)
    | (8'h01 << OUTPUT_UNDERVOLTAGE_FAULT_MASK_BIT)
    | (8'h01 << OUTPUT_LIMIT_RANGE_MASK_BIT) | (8'h01 << TURN_ON_TIMEOUT_MASK_BIT);
  localparam logic [7:0] OUTPUT_CURRENT_IMPL = (8'h01 << OVERCURRENT_FAULT_MASK_BIT)
    | (8'h01 << OVERCURRENT_WARNING_MASK_BIT) | (8'h01 << UNDERCURRENT_FAULT_MASK_BIT);
  localparam logic [7:0] INPUT_IMPL = (8'h01 << INPUT_OVERVOLTAGE_FAULT_MASK_BIT)
    | (8'h01 << INPUT_OVERVOLTAGE_WARNING_MASK_BIT)
    | (8'h01 << INPUT_UNDERVOLTAGE_WARNING_MASK_BIT) | (8'h01 << INSUFFICIENT_INPUT_MASK_BIT);
  localparam logic [7:0] TEMPERATURE_IMPL = (8'h01 << OVERTEMPERATURE_FAULT_MASK_BIT)
    | (8'h01 << OVERTEMPERATURE_WARNING_MASK_BIT);
  localparam logic [7:0] INPUT_STORED_BITS = 8'h01 << INSUFFICIENT_INPUT_MASK_BIT;
  localparam logic [7:0] INPUT_RESET = 8'h00;
  localparam logic [7:0] MASK_CLEAR = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {AMS_IDLE = 2'b01, AMS_ANSWER = 2'b10} ams_state_e;
  typedef logic [3:0][7:0] ams_bytes_t;

  // Maps a selector byte to {valid, group index}.
  function automatic logic [2:0] ams_decode_sel(input logic [7:0] sel);
    logic [2:0] r;
    r = 3'h0;
    case (sel)
      SEL_OUTPUT_VOLTAGE: r = {1'b1, GRP_OUTPUT_VOLTAGE};
      SEL_OUTPUT_CURRENT: r = {1'b1, GRP_OUTPUT_CURRENT};
      SEL_INPUT: r = {1'b1, GRP_INPUT};
      SEL_TEMPERATURE: r = {1'b1, GRP_TEMPERATURE};
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  // Returns the implemented mask bits of a group.
  function automatic logic [7:0] ams_impl(input logic [1:0] grp);
    logic [7:0] r;
    r = OUTPUT_VOLTAGE_IMPL;
    case (grp)
      GRP_OUTPUT_CURRENT: r = OUTPUT_CURRENT_IMPL;
      GRP_INPUT: r = INPUT_IMPL;
      GRP_TEMPERATURE: r = TEMPERATURE_IMPL;
      default: r = OUTPUT_VOLTAGE_IMPL;
    endcase
    return r;
  endfunction

endpackage

//--- hdl/ams_cfg_if.sv
// Carrier between the command decoder, the mask bank and the alert gate.
`timescale 1ns/1ps
interface ams_cfg_if;
  logic wr_en;
  logic [1:0] wr_grp;
  logic [7:0] wr_data;
  logic loaded;
  ams_pkg::ams_bytes_t mask;
  modport ctrl (output wr_en, output wr_grp, output wr_data, input loaded, input mask);
  modport bank (input wr_en, input wr_grp, input wr_data, output loaded, output mask);
  modport gate (input mask);
endinterface

//--- hdl/ams_mask_bank.sv
// Mask byte storage with stored-default load and write filtering.
`timescale 1ns/1ps
module ams_mask_bank (
  input wire logic clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire ams_pkg::ams_bytes_t nvm_mask, // Stored user defaults per group.
  ams_cfg_if.bank cfg // Write port and mask outputs.
);

  typedef struct packed {
    logic loaded;
    ams_pkg::ams_bytes_t mask;
  } ams_bank_s;

  ams_bank_s st;
  ams_bank_s next_st;

  // Loads the stored defaults once after reset, then applies filtered writes.
  always_comb begin
    next_st = st;
    if (!st.loaded) begin
      for (int g = 0; g < 4; g++) begin
        next_st.mask[g] = nvm_mask[g] & ams_pkg::ams_impl(2'(g));
      end
      next_st.mask[ams_pkg::GRP_INPUT] = (nvm_mask[ams_pkg::GRP_INPUT]
        & ams_pkg::INPUT_STORED_BITS) | ams_pkg::INPUT_RESET;
      next_st.loaded = 1'b1;
    end else if (cfg.wr_en) begin
      next_st.mask[cfg.wr_grp] = cfg.wr_data & ams_pkg::ams_impl(cfg.wr_grp);
    end
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cfg.mask = st.mask;
  assign cfg.loaded = st.loaded;

  a_unsupported_zero: assert property (@(posedge clk) disable iff (!reset_n)
    ((st.mask[0] & ~ams_pkg::OUTPUT_VOLTAGE_IMPL) == 8'h00)
    && ((st.mask[1] & ~ams_pkg::OUTPUT_CURRENT_IMPL) == 8'h00)
    && ((st.mask[2] & ~ams_pkg::INPUT_IMPL) == 8'h00)
    && ((st.mask[3] & ~ams_pkg::TEMPERATURE_IMPL) == 8'h00))
    else $error("Unsupported mask bit reads nonzero.");

  a_input_reset_load: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(st.loaded) |-> (st.mask[2][7:5] == 3'h0)
      && (st.mask[2][3] == $past(nvm_mask[2][3])))
    else $error("Input mask reset value wrong.");

  a_stored_load: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(st.loaded) |-> st.mask[0] == ($past(nvm_mask[0]) & ams_pkg::OUTPUT_VOLTAGE_IMPL))
    else $error("Stored default not loaded.");

endmodule // ams_mask_bank

//--- hdl/ams_alert_gate.sv
// Combines status conditions with their masks into the alert request.
`timescale 1ns/1ps
module ams_alert_gate (
  input wire logic clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire ams_pkg::ams_bytes_t status, // Live status bytes per group.
  ams_cfg_if.gate cfg, // Current mask bytes.
  output logic alert_request // Registered alert request, active high.
);

  typedef struct packed {
    logic alert;
  } ams_gate_s;

  ams_gate_s st;
  ams_gate_s next_st;

  // A set mask bit only removes its condition from the alert; status is untouched.
  always_comb begin
    next_st = st;
    next_st.alert = |(status & ~cfg.mask);
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign alert_request = st.alert;

  a_masked_blocks: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 alert_request |-> $past(|(status & ~cfg.mask)))
    else $error("Alert raised by a masked condition.");

  a_unmasked_raises: assert property (@(posedge clk) disable iff (!reset_n)
    (|(status & ~cfg.mask)) |=> alert_request)
    else $error("Unmasked condition did not raise alert.");

endmodule // ams_alert_gate

//--- hdl/ams_alert_mask.sv
// Top of the alert source mask bank: command decoder, mask store and alert gate.
//
// Summary of operation
// - Selector 7Ah addresses output voltage mask.
// - Selector 7Bh addresses output current mask.
// - Selector 7Ch addresses input mask.
// - Selector 7Dh addresses temperature mask.
// - Mask bit 0 lets alert; 1 blocks.
// - Voltage mask bits 7:2 writable, 1:0 zero.
// - Current mask bits 7,5,4 writable, rest zero.
// - Input bits 7:5 reset zero, 3 stored.
// - Temperature bits 7:6 writable, 5:0 zero.
// - Write word: low selector, high mask.
// - Process call: one-byte selector, one-byte mask back.
// - Mask never stops status bits being set.
`timescale 1ns/1ps
module ams_alert_mask (
  input wire logic clk, // System clock, 200 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic cmd_valid, // Decoded bus transaction present.
  output logic cmd_ready, // Transaction may be taken this cycle.
  input wire logic cmd_call, // 1: process call read, 0: write word.
  input wire logic [7:0] cmd_code, // Command code of the transaction.
  input wire logic [7:0] cmd_data_lo, // Write word low data byte.
  input wire logic [7:0] cmd_data_hi, // Write word high data byte.
  input wire logic [7:0] cmd_block_count, // Process call write block count.
  input wire logic [7:0] cmd_block_data, // Process call first block byte.
  input wire logic [7:0] phase_select, // Current phase selection.
  output logic rsp_valid, // Answer present, one cycle.
  output logic rsp_ok, // Transaction accepted.
  output logic [7:0] rsp_count, // Read block byte count.
  output logic [7:0] rsp_data, // Read block data byte.
  input wire logic [7:0] status_output_voltage, // Output voltage status group.
  input wire logic [7:0] status_output_current, // Output current status group.
  input wire logic [7:0] status_input, // Input status group.
  input wire logic [7:0] status_temperature, // Temperature status group.
  input wire logic [7:0] nvm_output_voltage, // Stored output voltage mask.
  input wire logic [7:0] nvm_output_current, // Stored output current mask.
  input wire logic [7:0] nvm_input, // Stored input mask.
  input wire logic [7:0] nvm_temperature, // Stored temperature mask.
  output logic alert_request // Alert line request, active high.
);

  // ****************************************************************
  // Internal carriers
  // ****************************************************************
  ams_cfg_if cfg ();

  ams_pkg::ams_bytes_t status_bytes;
  ams_pkg::ams_bytes_t nvm_bytes;

  // Groups the per-group ports into arrays indexed by group number.
  assign status_bytes = {status_temperature, status_input, status_output_current,
    status_output_voltage};
  assign nvm_bytes = {nvm_temperature, nvm_input, nvm_output_current, nvm_output_voltage};

  // ****************************************************************
  // Command decoder state
  // ****************************************************************
  typedef struct packed {
    ams_pkg::ams_state_e state;
    logic ok;
    logic [7:0] count;
    logic [7:0] data;
    logic wr_en;
    logic [1:0] wr_grp;
    logic [7:0] wr_data;
  } ams_ctl_s;

  ams_ctl_s st;
  ams_ctl_s next_st;

  logic take;
  logic [7:0] sel_byte;
  logic [2:0] sel_dec;
  logic addr_ok;
  logic shape_ok;
  logic accept;

  // A transaction is taken only once the stored defaults are in place.
  assign cmd_ready = (st.state == ams_pkg::AMS_IDLE) && cfg.loaded;
  assign take = cmd_valid && cmd_ready;

  // The selector sits in the low data byte of a write or the block byte of a read.
  assign sel_byte = cmd_call ? cmd_block_data : cmd_data_lo;
  assign sel_dec = ams_pkg::ams_decode_sel(sel_byte);
  assign addr_ok = (cmd_code == ams_pkg::CMD_ALERT_SOURCE_MASK) && sel_dec[2];
  assign shape_ok = !cmd_call || (cmd_block_count == ams_pkg::READ_BLOCK_LEN);
  assign accept = addr_ok && shape_ok
    && (phase_select == ams_pkg::PHASE_ALL);

  // Decodes one transaction in idle, answers it the next cycle, and returns.
  always_comb begin
    next_st = st;
    next_st.wr_en = 1'b0;
    unique case (st.state)
      ams_pkg::AMS_IDLE: begin
        if (take) begin
          next_st.state = ams_pkg::AMS_ANSWER;
          next_st.ok = accept;
          next_st.wr_grp = sel_dec[1:0];
          next_st.wr_data = cmd_data_hi;
          next_st.wr_en = accept && !cmd_call;
          if (cmd_call && accept) begin
            next_st.count = ams_pkg::READ_BLOCK_LEN;
            next_st.data = cfg.mask[sel_dec[1:0]];
          end else begin
            next_st.count = 8'h00;
            next_st.data = 8'h00;
          end
        end
      end
      ams_pkg::AMS_ANSWER: begin
        next_st.state = ams_pkg::AMS_IDLE;
      end
      default: begin
        next_st.state = ams_pkg::AMS_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{state: ams_pkg::AMS_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs and carrier drive
  // ****************************************************************
  assign rsp_valid = (st.state == ams_pkg::AMS_ANSWER);
  assign rsp_ok = st.ok;
  assign rsp_count = st.count;
  assign rsp_data = st.data;
  assign cfg.wr_en = st.wr_en;
  assign cfg.wr_grp = st.wr_grp;
  assign cfg.wr_data = st.wr_data;

  // ****************************************************************
  // Submodules
  // ****************************************************************
  ams_mask_bank u_bank (
    .clk(clk),
    .reset_n(reset_n),
    .nvm_mask(nvm_bytes),
    .cfg(cfg.bank)
  );

  ams_alert_gate u_gate (
    .clk(clk),
    .reset_n(reset_n),
    .status(status_bytes),
    .cfg(cfg.gate),
    .alert_request(alert_request)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_good_write(logic [7:0] sel);
    take && !cmd_call && cmd_code == ams_pkg::CMD_ALERT_SOURCE_MASK
      && cmd_data_lo == sel && phase_select == ams_pkg::PHASE_ALL;
  endsequence

  sequence s_good_read(logic [7:0] sel);
    take && cmd_call && cmd_code == ams_pkg::CMD_ALERT_SOURCE_MASK
      && cmd_block_data == sel && cmd_block_count == ams_pkg::READ_BLOCK_LEN
      && phase_select == ams_pkg::PHASE_ALL;
  endsequence

  a_answer_one_cycle: assert property (take |=> rsp_valid ##1 !rsp_valid)
    else $error("Answer not a single cycle after take.");

  a_vout_write: assert property (s_good_write(ams_pkg::SEL_OUTPUT_VOLTAGE)
    |-> ##2 cfg.mask[0] == ($past(cmd_data_hi, 2) & 8'hfc))
    else $error("Output voltage mask write wrong.");

  a_iout_write: assert property (s_good_write(ams_pkg::SEL_OUTPUT_CURRENT)
    |-> ##2 cfg.mask[1] == ($past(cmd_data_hi, 2) & 8'hb0))
    else $error("Output current mask write wrong.");

  a_input_write: assert property (s_good_write(ams_pkg::SEL_INPUT)
    |-> ##2 cfg.mask[2] == ($past(cmd_data_hi, 2) & 8'he8))
    else $error("Input mask write wrong.");

  a_temp_write: assert property (s_good_write(ams_pkg::SEL_TEMPERATURE)
    |-> ##2 cfg.mask[3] == ($past(cmd_data_hi, 2) & 8'hc0))
    else $error("Temperature mask write wrong.");

  a_read_back: assert property (s_good_read(ams_pkg::SEL_INPUT)
    |=> rsp_ok && rsp_count == 8'h01 && rsp_data == $past(cfg.mask[2]))
    else $error("Read block answer wrong.");

  a_phase_refused: assert property (take && phase_select != 8'hff
    |=> !rsp_ok && !cfg.wr_en)
    else $error("Access outside phase FFh accepted.");

  a_wrong_code: assert property (take && cmd_code != 8'h1b
    |=> !rsp_ok && !cfg.wr_en && rsp_count == 8'h00)
    else $error("Foreign command code accepted.");

  a_bad_block_len: assert property (take && cmd_call && cmd_block_count != 8'h01
    |=> !rsp_ok)
    else $error("Read with wrong block length accepted.");

  // ****************************************************************
  // Read-back checks per group
  // ****************************************************************
  // An accepted read returns the output voltage mask as it stood at the take.
  a_vout_read: assert property (s_good_read(ams_pkg::SEL_OUTPUT_VOLTAGE)
    |=> rsp_ok && rsp_count == 8'h01 && rsp_data == $past(cfg.mask[0]))
    else $error("Output voltage read answer wrong.");

  // An accepted read returns the output current mask as it stood at the take.
  a_iout_read: assert property (s_good_read(ams_pkg::SEL_OUTPUT_CURRENT)
    |=> rsp_ok && rsp_count == 8'h01 && rsp_data == $past(cfg.mask[1]))
    else $error("Output current read answer wrong.");

  // An accepted read returns the temperature mask as it stood at the take.
  a_temp_read: assert property (s_good_read(ams_pkg::SEL_TEMPERATURE)
    |=> rsp_ok && rsp_count == 8'h01 && rsp_data == $past(cfg.mask[3]))
    else $error("Temperature read answer wrong.");

  // ****************************************************************
  // Unsupported bit checks per group
  // ****************************************************************
  // Output voltage bits 1:0 never hold a one.
  a_vout_low_zero: assert property (cfg.mask[0][1:0] == 2'h0)
    else $error("Output voltage mask bits 1:0 nonzero.");

  // Output current bits 6 and 3:0 never hold a one.
  a_iout_gaps_zero: assert property ((cfg.mask[1] & 8'h4f) == 8'h00)
    else $error("Output current unsupported bits nonzero.");

  // Input bits 4 and 2:0 never hold a one.
  a_input_gaps_zero: assert property ((cfg.mask[2] & 8'h17) == 8'h00)
    else $error("Input unsupported bits nonzero.");

  // Temperature bits 5:0 never hold a one.
  a_temp_low_zero: assert property (cfg.mask[3][5:0] == 6'h00)
    else $error("Temperature mask bits 5:0 nonzero.");

  // ****************************************************************
  // Refusal and handshake checks
  // ****************************************************************
  // A selector outside the four groups is refused and writes nothing.
  a_bad_selector: assert property (take && (sel_byte < 8'h7a || sel_byte > 8'h7d)
    |=> !rsp_ok && !cfg.wr_en && rsp_count == 8'h00)
    else $error("Unknown selector accepted.");

  // The decoder is busy while it answers, so nothing is taken then.
  a_busy_in_answer: assert property (rsp_valid |-> !cmd_ready)
    else $error("Ready shown during the answer cycle.");

  // Nothing is taken before the stored defaults are in place.
  a_ready_after_load: assert property (!cfg.loaded |-> !cmd_ready)
    else $error("Ready shown before defaults loaded.");

  // A read call never strobes a mask store.
  a_read_no_write: assert property (take && cmd_call |=> !cfg.wr_en)
    else $error("Read call wrote a mask.");

  // A write answers with an empty block.
  a_write_empty: assert property (take && !cmd_call
    |=> rsp_count == 8'h00 && rsp_data == 8'h00)
    else $error("Write answer carried data.");

  // Masks change only through a store strobe once defaults are loaded.
  a_mask_stable: assert property (cfg.loaded && !cfg.wr_en |=> $stable(cfg.mask))
    else $error("Mask changed without a write.");

  // A write of any group that passes every decode test.
  sequence s_any_good_write;
    take && !cmd_call && cmd_code == ams_pkg::CMD_ALERT_SOURCE_MASK
      && cmd_data_lo >= 8'h7a && cmd_data_lo <= 8'h7d
      && phase_select == ams_pkg::PHASE_ALL;
  endsequence

  // Answer and store strobe stand together in the cycle after the take.
  sequence s_write_answer;
    rsp_valid && rsp_ok && cfg.wr_en;
  endsequence

  // An accepted write answers with the store strobe, and both drop a cycle later.
  a_write_steps: assert property (s_any_good_write
    |=> s_write_answer ##1 (!rsp_valid && !cfg.wr_en))
    else $error("Write answer and store strobe out of step.");

endmodule // ams_alert_mask

//--- dv/ams_host_model.sv
// Host controller model that offers decoded mask transactions to the block.
`timescale 1ns/1ps
module ams_host_model (
  input wire logic clk, // System clock.
  input wire logic cmd_ready, // Block can take a request.
  input wire logic rsp_valid, // Answer strobe.
  input wire logic rsp_ok, // Answer accepted flag.
  input wire logic [7:0] rsp_count, // Answer byte count.
  input wire logic [7:0] rsp_data, // Answer data byte.
  output logic cmd_valid, // Request offered.
  output logic cmd_call, // Read call when high.
  output logic [7:0] cmd_code, // Command code.
  output logic [7:0] cmd_data_lo, // Selector of a write.
  output logic [7:0] cmd_data_hi, // Mask byte of a write.
  output logic [7:0] cmd_block_count, // Block count of a read.
  output logic [7:0] cmd_block_data, // Selector of a read.
  output logic [7:0] phase_select // Phase selection.
);
  // ****************************************************************
  // Request driver
  // ****************************************************************
  // Nothing is offered at time zero and the phase selects all.
  initial begin
    cmd_valid = 1'b0;
    phase_select = 8'hff;
    {cmd_call, cmd_code, cmd_data_lo, cmd_data_hi, cmd_block_count, cmd_block_data} = '0;
  end

  // Offers one request at a falling edge, holds it until it is taken, then samples the
  // answer one cycle later and withdraws, scrambling the released data fields.
  task automatic xfer(input logic call, input logic [7:0] code, sel, val, cnt, phase,
    output logic [17:0] ans, output logic to);
    int n;
    n = 0;
    @(negedge clk);
    phase_select = phase;
    cmd_call = call;
    cmd_code = code;
    cmd_data_lo = sel;
    cmd_data_hi = val;
    cmd_block_count = cnt;
    cmd_block_data = sel;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    ans = {rsp_valid, rsp_ok, rsp_count, rsp_data};
    to = (n == 20);
    cmd_valid = 1'b0;
    cmd_data_lo = ~cmd_data_lo;
    cmd_data_hi = ~cmd_data_hi;
    cmd_block_data = ~cmd_block_data;
  endtask
endmodule // ams_host_model

//--- dv/test_alert_mask_status_groups.sv
// Self-checking testbench of the alert source mask bank.
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module test_alert_mask_status_groups;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  typedef struct packed {logic [7:0] sel; logic [7:0] val; logic [7:0] exp;} ams_row_s;
  localparam logic [7:0] KEEP [4] = '{8'hfc, 8'hb0, 8'h08, 8'hc0};
  localparam ams_row_s ROWS [9] = '{'{8'h7a, 8'hff, 8'hfc}, '{8'h7a, 8'h03, 8'h00},
    '{8'h7b, 8'hff, 8'hb0}, '{8'h7b, 8'h4f, 8'h00}, '{8'h7c, 8'hff, 8'he8},
    '{8'h7c, 8'h17, 8'h00}, '{8'h7d, 8'hff, 8'hc0}, '{8'h7d, 8'h3f, 8'h00},
    '{8'h7a, 8'h54, 8'h54}};
  logic clk, reset_n, cmd_valid, cmd_ready, cmd_call, rsp_valid, rsp_ok, alert_request;
  logic [7:0] cmd_code, cmd_data_lo, cmd_data_hi, cmd_block_count, cmd_block_data;
  logic [7:0] phase_select, rsp_count, rsp_data;
  logic [7:0] st [4];
  logic [7:0] nvm [4];
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;

  ams_host_model host_u (.clk(clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_ok(rsp_ok), .rsp_count(rsp_count), .rsp_data(rsp_data), .cmd_valid(cmd_valid),
    .cmd_call(cmd_call), .cmd_code(cmd_code), .cmd_data_lo(cmd_data_lo),
    .cmd_data_hi(cmd_data_hi), .cmd_block_count(cmd_block_count),
    .cmd_block_data(cmd_block_data), .phase_select(phase_select));

  ams_alert_mask dut_u (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_call(cmd_call), .cmd_code(cmd_code),
    .cmd_data_lo(cmd_data_lo), .cmd_data_hi(cmd_data_hi), .cmd_block_count(cmd_block_count),
    .cmd_block_data(cmd_block_data), .phase_select(phase_select), .rsp_valid(rsp_valid),
    .rsp_ok(rsp_ok), .rsp_count(rsp_count), .rsp_data(rsp_data),
    .status_output_voltage(st[0]), .status_output_current(st[1]), .status_input(st[2]),
    .status_temperature(st[3]), .nvm_output_voltage(nvm[0]), .nvm_output_current(nvm[1]),
    .nvm_input(nvm[2]), .nvm_temperature(nvm[3]), .alert_request(alert_request));

  // Clock of 5 ns period.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cuts a hung run short after far more cycles than the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      end_sim();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Runs one transaction and compares {valid, ok, count, data} of its answer.
  task automatic op(input logic call, input logic [7:0] code, sel, val, cnt, phase,
    input logic [17:0] exp);
    logic [17:0] a;
    logic to;
    host_u.xfer(call, code, sel, val, cnt, phase, a, to);
    if (to) fail_count++;
    `CHK(a, exp)
  endtask

  // Write word with selector low and mask high; accepted writes return no data.
  task automatic wr(input logic [7:0] sel, val);
    op(1'b0, 8'h1b, sel, val, 8'h01, 8'hff, 18'h30000);
  endtask

  // One-byte process call read; the answer holds one byte.
  task automatic rd(input logic [7:0] sel, exp);
    op(1'b1, 8'h1b, sel, 8'h00, 8'h01, 8'hff, {10'h301, exp});
  endtask

  // Resets with the given stored defaults and reads back every group.
  task automatic reset_check(input logic [7:0] v);
    nvm = '{default: v};
    reset_n = 1'b0;
    repeat (12) @(negedge clk);
    `CHK({cmd_ready, rsp_valid, rsp_ok, alert_request, rsp_count, rsp_data}, 20'h00000)
    reset_n = 1'b1;
    for (int g = 0; g < 4; g++) rd(8'h7a + 8'(g), v & KEEP[g]);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // A first reset, the table of writes and readbacks, then refusals, alert gating and a second reset.
  initial begin
    st = '{default: 8'h00};
    reset_check(8'hff);
    for (int r = 0; r < 9; r++) begin
      wr(ROWS[r].sel, ROWS[r].val);
      rd(ROWS[r].sel, ROWS[r].exp);
    end
    op(1'b0, 8'h1c, 8'h7b, 8'hff, 8'h01, 8'hff, 18'h20000);
    for (int i = 0; i < 6; i++) begin
      op(i[0], 8'h1b, 8'h7e + 8'(i / 2), 8'hff, 8'h01, 8'hff, 18'h20000);
    end
    op(1'b0, 8'h1b, 8'h7b, 8'hff, 8'h01, 8'h7f, 18'h20000);
    op(1'b1, 8'h1b, 8'h7a, 8'h00, 8'h01, 8'h00, 18'h20000);
    op(1'b1, 8'h1b, 8'h7a, 8'h00, 8'h02, 8'hff, 18'h20000);
    rd(8'h7b, 8'h00);
    rd(8'h7a, 8'h54);
    st[0] = 8'h04;
    @(negedge clk);
    `CHK(alert_request, 1'b0)
    st[0] = 8'h08;
    @(negedge clk);
    `CHK(alert_request, 1'b1)
    st[0] = 8'h00;
    for (int g = 0; g < 4; g++) begin
      @(negedge clk);
      `CHK(alert_request, 1'b0)
      st[g] = 8'h80;
      @(negedge clk);
      `CHK(alert_request, 1'b1)
      wr(8'h7a + 8'(g), 8'h80);
      repeat (2) @(negedge clk);
      `CHK(alert_request, 1'b0)
      wr(8'h7a + 8'(g), 8'h00);
      repeat (2) @(negedge clk);
      `CHK(alert_request, 1'b1)
      st[g] = 8'h00;
    end
    @(negedge clk);
    reset_check(8'h5a);
    end_sim();
  end
endmodule // test_alert_mask_status_groups
